// ===== hdl/fpp_device.sv
// Device end of the parallel configuration port
`timescale 1ns/10ps
`include "fpp_regs.svh"
module fpp_device #(
  parameter int por_cycles = `FPP_POR_CYC
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  fpp_link_if.dev                      link,
  input  wire logic                    use_user_clock,
  input  wire logic                    user_startup_clock,
  input  wire logic [`FPP_BUS_W-1:0]   user_io_out,
  input  wire logic                    user_io_oe_n,
  output logic [`FPP_BUS_W-1:0]        cfg_data,
  output logic                         cfg_valid,
  input  wire logic                    cfg_ready,
  output logic                         user_mode,
  output logic                         config_error,
  output fpp_pkg::fpp_dev_state_t      phase
);
  import fpp_pkg::*;

  logic [1:0]            req_s;
  logic [1:0]            st_s;
  logic [1:0]            ck_s;
  logic                  ck_d;
  logic [1:0]            uc_s;
  logic                  uc_d;
  logic [`FPP_BUS_W-1:0] d_s1;
  logic [`FPP_BUS_W-1:0] d_s2;
  logic                  req_hi;
  logic                  st_hi;
  logic                  ck_rise;
  logic                  uc_rise;

  fpp_dev_state_t        state;
  fpp_dev_state_t        next_state;
  logic [23:0]           cnt;
  logic [23:0]           next_cnt;
  logic [15:0]           bytes;
  logic [15:0]           next_bytes;
  logic                  stat_oe_n;
  logic                  next_stat_oe_n;
  logic                  done_oe_n;
  logic                  next_done_oe_n;
  logic                  err;
  logic                  next_err;
  logic                  umode;
  logic                  next_umode;
  logic                  pre;
  logic                  next_pre;
  logic [`FPP_BUS_W-1:0] uio;
  logic [`FPP_BUS_W-1:0] next_uio;
  logic                  uio_oe_n;
  logic                  next_uio_oe_n;
  logic                  push;
  logic                  fifo_ready;

  // Every pin input is two flops away from any logic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_s <= 2'h3;
      st_s  <= 2'h0;
      ck_s  <= 2'h0;
      ck_d  <= 1'b0;
      uc_s  <= 2'h0;
      uc_d  <= 1'b0;
      d_s1  <= '0;
      d_s2  <= '0;
    end else begin
      req_s <= {req_s[0], link.config_req_n};
      st_s  <= {st_s[0], link.status_in};
      ck_s  <= {ck_s[0], link.config_clock};
      ck_d  <= ck_s[1];
      uc_s  <= {uc_s[0], user_startup_clock};
      uc_d  <= uc_s[1];
      d_s1  <= link.data;
      d_s2  <= d_s1;
    end
  end

  assign req_hi  = req_s[1];
  assign st_hi   = st_s[1];
  assign ck_rise = ck_s[1] & ~ck_d;
  assign uc_rise = uc_s[1] & ~uc_d;

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_bytes     = bytes;
    next_stat_oe_n = stat_oe_n;
    next_done_oe_n = done_oe_n;
    next_err       = err;
    next_umode     = umode;
    next_pre       = pre;
    next_uio       = uio;
    next_uio_oe_n  = uio_oe_n;
    push           = 1'b0;
    case (state)
      D_POR: begin
        next_cnt = cnt + 24'h1;
        if (cnt == 24'(por_cycles - 1)) begin
          next_state     = D_WAIT;
          next_cnt       = 24'h0;
          next_stat_oe_n = 1'b1;
        end
      end
      D_RESET: begin
        if (cnt != 24'(`FPP_STATUS_MIN_CYC)) begin
          next_cnt = cnt + 24'h1;
        end
        // Release as soon as both the minimum low time and the request allow
        if (req_hi && cnt == 24'(`FPP_STATUS_MIN_CYC)) begin
          next_state     = D_WAIT;
          next_stat_oe_n = 1'b1;
        end
      end
      D_WAIT: begin
        if (req_hi && st_hi) begin
          next_state = D_CONFIG;
          next_bytes = 16'h0;
        end
      end
      D_CONFIG: begin
        if (!st_hi) begin
          next_state = D_WAIT;
        end else if (ck_rise) begin
          // The link cannot be stalled, so a full buffer is a load error
          if (!fifo_ready) begin
            next_state     = D_ERROR;
            next_stat_oe_n = 1'b0;
            next_err       = 1'b1;
          end else begin
            push       = 1'b1;
            next_bytes = bytes + 16'h1;
            if (bytes == 16'(`FPP_IMAGE_BYTES - 1)) begin
              next_state     = D_START;
              next_done_oe_n = 1'b1;
              next_cnt       = 24'h0;
              next_pre       = 1'b0;
            end
          end
        end
      end
      D_START: begin
        if (!use_user_clock) begin
          next_cnt = cnt + 24'h1;
          if (cnt == 24'(`FPP_CD2UM_MIN_CYC - 1)) begin
            next_state = D_USER;
            next_umode = 1'b1;
          end
        end else if (!pre) begin
          next_cnt = cnt + 24'h1;
          if (cnt == 24'(`FPP_CD2CU_CYC - 1)) begin
            next_pre = 1'b1;
            next_cnt = 24'h0;
          end
        end else if (uc_rise) begin
          next_cnt = cnt + 24'h1;
          if (cnt == 24'(`FPP_USR_EDGES - 1)) begin
            next_state = D_USER;
            next_umode = 1'b1;
          end
        end
      end
      D_USER: begin
        next_uio      = user_io_out;
        next_uio_oe_n = user_io_oe_n;
      end
      D_ERROR: begin
        next_stat_oe_n = 1'b0;
      end
      default: begin
        next_state = D_POR;
      end
    endcase
    // A request pulse wins over every state except D_POR and D_RESET; in D_RESET the low-time count keeps running
    if (!req_hi && state != D_POR && state != D_RESET) begin
      next_state     = D_RESET;
      next_cnt       = 24'h0;
      next_stat_oe_n = 1'b0;
      next_done_oe_n = 1'b0;
      next_err       = 1'b0;
      next_umode     = 1'b0;
      next_uio_oe_n  = 1'b1;
      push           = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state     <= D_POR;
      cnt       <= 24'h0;
      bytes     <= 16'h0;
      stat_oe_n <= 1'b0;
      done_oe_n <= 1'b0;
      err       <= 1'b0;
      umode     <= 1'b0;
      pre       <= 1'b0;
      uio       <= '0;
      uio_oe_n  <= 1'b1;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      bytes     <= next_bytes;
      stat_oe_n <= next_stat_oe_n;
      done_oe_n <= next_done_oe_n;
      err       <= next_err;
      umode     <= next_umode;
      pre       <= next_pre;
      uio       <= next_uio;
      uio_oe_n  <= next_uio_oe_n;
    end
  end

  fpp_fifo #(
    .W     (`FPP_BUS_W),
    .DEPTH (`FPP_FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .rst       (rst),
    .in_data   (d_s2),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (cfg_data),
    .out_valid (cfg_valid),
    .out_ready (cfg_ready)
  );

  assign link.status_out    = 1'b0;
  assign link.status_oe_n   = stat_oe_n;
  assign link.done_out      = 1'b0;
  assign link.done_oe_n     = done_oe_n;
  assign link.dev_data      = uio;
  assign link.dev_data_oe_n = uio_oe_n;
  assign user_mode          = umode;
  assign config_error       = err;
  assign phase              = state;
endmodule

// ===== hdl/fpp_regs.svh
// Timing counts and bus constants for the parallel configuration port
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH
`define FPP_CLK_NS          8
`define FPP_BUS_W           8
`define FPP_FIFO_DEPTH      16
`define FPP_IMAGE_BYTES     32
`define FPP_POR_MS          12
`define FPP_POR_CYC         (((`FPP_POR_MS * 1000000) + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`define FPP_CF2CD_NS        800
`define FPP_CF2CD_CYC       (`FPP_CF2CD_NS / `FPP_CLK_NS)
`define FPP_CF2ST0_NS       800
`define FPP_CF2ST0_CYC      (`FPP_CF2ST0_NS / `FPP_CLK_NS)
`define FPP_CFG_US          2
`define FPP_CFG_CYC         (((`FPP_CFG_US * 1000) + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`define FPP_STATUS_MIN_US   10
`define FPP_STATUS_MIN_CYC  (((`FPP_STATUS_MIN_US * 1000) + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`define FPP_STATUS_MAX_US   100
`define FPP_STATUS_MAX_CYC  ((`FPP_STATUS_MAX_US * 1000) / `FPP_CLK_NS)
`define FPP_CF2ST1_US       100
`define FPP_CF2ST1_CYC      ((`FPP_CF2ST1_US * 1000) / `FPP_CLK_NS)
`define FPP_CF2CK_US        100
`define FPP_CF2CK_CYC       (((`FPP_CF2CK_US * 1000) + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`define FPP_ST2CK_US        2
`define FPP_ST2CK_CYC       (((`FPP_ST2CK_US * 1000) + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`define FPP_CD2UM_MIN_US    20
`define FPP_CD2UM_MIN_CYC   (((`FPP_CD2UM_MIN_US * 1000) + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`define FPP_CD2UM_MAX_US    40
`define FPP_CD2UM_MAX_CYC   ((`FPP_CD2UM_MAX_US * 1000) / `FPP_CLK_NS)
`define FPP_CLK_MAX_NS      125
`define FPP_CD2CU_CYC       (((4 * `FPP_CLK_MAX_NS) + `FPP_CLK_NS - 1) / `FPP_CLK_NS)
`define FPP_USR_EDGES       299
`define FPP_HALF_CYC        8
`endif

// ===== hdl/fpp_pkg.sv
// State types shared by both ends of the configuration port
package fpp_pkg;
  typedef enum logic [2:0] {D_POR, D_RESET, D_WAIT, D_CONFIG, D_START, D_USER, D_ERROR} fpp_dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_REQ, H_WAIT, H_GAP, H_LOW, H_HIGH, H_DONE} fpp_host_state_t;
endpackage

// ===== hdl/fpp_link_if.sv
// Pin bundle joining the configuration host and the device
`timescale 1ns/10ps
`include "fpp_regs.svh"
interface fpp_link_if;
  logic                  config_req_n;
  logic                  config_clock;
  logic                  status_out;
  logic                  status_oe_n;
  logic                  status_in;
  logic                  done_out;
  logic                  done_oe_n;
  logic                  done_in;
  logic [`FPP_BUS_W-1:0] host_data;
  logic                  host_data_oe_n;
  logic [`FPP_BUS_W-1:0] dev_data;
  logic                  dev_data_oe_n;
  logic [`FPP_BUS_W-1:0] data;

  // Open-drain lines float high through the pull-up when nobody pulls
  assign status_in = status_oe_n ? 1'b1 : status_out;
  assign done_in   = done_oe_n ? 1'b1 : done_out;
  assign data      = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : {`FPP_BUS_W{1'b1}});

  modport dev (
    input  config_req_n,
    input  config_clock,
    input  status_in,
    input  done_in,
    input  data,
    output status_out,
    output status_oe_n,
    output done_out,
    output done_oe_n,
    output dev_data,
    output dev_data_oe_n
  );

  modport host (
    output config_req_n,
    output config_clock,
    output host_data,
    output host_data_oe_n,
    input  status_in,
    input  done_in,
    input  data
  );
endinterface

// ===== hdl/fpp_fifo.sv
// Byte buffer between the configuration pins and the loader
`timescale 1ns/10ps
module fpp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic [AW:0]  fill;

  assign fill      = wr_ptr - rd_ptr;
  assign in_ready  = fill != (AW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (in_valid && in_ready) begin
      next_wr_ptr = wr_ptr + (AW+1)'(1);
    end
    if (out_valid && out_ready) begin
      next_rd_ptr = rd_ptr + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage has no reset so it can map to plain memory
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// ===== hdl/fpp_host.sv
// Host end that drives a configuration image into the device
`timescale 1ns/10ps
`include "fpp_regs.svh"
module fpp_host #(
  parameter int cf2ck_cycles = `FPP_CF2CK_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  fpp_link_if.host                   link,
  input  wire logic                  start,
  input  wire logic [`FPP_BUS_W-1:0] src_data,
  input  wire logic                  src_valid,
  output logic                       src_ready,
  output logic                       busy,
  output logic                       config_done,
  output logic                       config_error,
  output fpp_pkg::fpp_host_state_t   phase
);
  import fpp_pkg::*;

  logic [1:0]            st_s;
  logic [1:0]            dn_s;
  fpp_host_state_t       state;
  fpp_host_state_t       next_state;
  logic [15:0]           cnt;
  logic [15:0]           next_cnt;
  logic                  req_n;
  logic                  next_req_n;
  logic                  ck;
  logic                  next_ck;
  logic [`FPP_BUS_W-1:0] dat;
  logic [`FPP_BUS_W-1:0] next_dat;
  logic                  dat_oe_n;
  logic                  next_dat_oe_n;
  logic                  rdy;
  logic                  next_rdy;
  logic                  have;
  logic                  next_have;
  logic                  err;
  logic                  next_err;
  logic                  done;
  logic                  next_done;
  logic                  bsy;
  logic                  next_bsy;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_s <= 2'h0;
      dn_s <= 2'h0;
    end else begin
      st_s <= {st_s[0], link.status_in};
      dn_s <= {dn_s[0], link.done_in};
    end
  end

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_req_n    = req_n;
    next_ck       = ck;
    next_dat      = dat;
    next_dat_oe_n = dat_oe_n;
    next_rdy      = rdy;
    next_have     = have;
    next_err      = err;
    next_done     = done;
    next_bsy      = bsy;
    if (cnt != 16'hffff) begin
      next_cnt = cnt + 16'h1;
    end
    case (state)
      H_IDLE, H_DONE: begin
        if (start) begin
          next_state = H_REQ;
          next_req_n = 1'b0;
          next_cnt   = 16'h0;
          next_err   = 1'b0;
          next_done  = 1'b0;
          next_bsy   = 1'b1;
        end
      end
      H_REQ: begin
        if (cnt == 16'(`FPP_CFG_CYC - 1)) begin
          next_state = H_WAIT;
          next_req_n = 1'b1;
          next_cnt   = 16'h0;
        end
      end
      H_WAIT: begin
        if (st_s[1] && cnt >= 16'(cf2ck_cycles - 1)) begin
          next_state = H_GAP;
          next_cnt   = 16'h0;
        end
      end
      H_GAP: begin
        if (cnt == 16'(`FPP_ST2CK_CYC - 1)) begin
          next_state = H_LOW;
          next_cnt   = 16'h0;
        end
      end
      H_LOW: begin
        // Clock waits low until a byte is on the pins
        if (!have) begin
          next_rdy = 1'b1;
          next_cnt = 16'h0;
          if (rdy && src_valid) begin
            next_rdy      = 1'b0;
            next_have     = 1'b1;
            next_dat      = src_data;
            next_dat_oe_n = 1'b0;
          end
        end else if (cnt == 16'(`FPP_HALF_CYC - 1)) begin
          next_state = H_HIGH;
          next_ck    = 1'b1;
          next_cnt   = 16'h0;
          next_have  = 1'b0;
        end
      end
      H_HIGH: begin
        if (cnt == 16'(`FPP_HALF_CYC - 1)) begin
          next_state = H_LOW;
          next_ck    = 1'b0;
          next_cnt   = 16'h0;
        end
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
    if (state == H_GAP || state == H_LOW || state == H_HIGH) begin
      if (dn_s[1]) begin
        next_state    = H_DONE;
        next_ck       = 1'b0;
        next_dat_oe_n = 1'b1;
        next_rdy      = 1'b0;
        next_have     = 1'b0;
        next_done     = 1'b1;
        next_bsy      = 1'b0;
      end else if (!st_s[1]) begin
        next_state    = H_REQ;
        next_req_n    = 1'b0;
        next_cnt      = 16'h0;
        next_ck       = 1'b0;
        next_dat_oe_n = 1'b1;
        next_rdy      = 1'b0;
        next_have     = 1'b0;
        next_err      = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state    <= H_IDLE;
      cnt      <= 16'h0;
      req_n    <= 1'b1;
      ck       <= 1'b0;
      dat      <= '0;
      dat_oe_n <= 1'b1;
      rdy      <= 1'b0;
      have     <= 1'b0;
      err      <= 1'b0;
      done     <= 1'b0;
      bsy      <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      req_n    <= next_req_n;
      ck       <= next_ck;
      dat      <= next_dat;
      dat_oe_n <= next_dat_oe_n;
      rdy      <= next_rdy;
      have     <= next_have;
      err      <= next_err;
      done     <= next_done;
      bsy      <= next_bsy;
    end
  end

  assign link.config_req_n   = req_n;
  assign link.config_clock   = ck;
  assign link.host_data      = dat;
  assign link.host_data_oe_n = dat_oe_n;
  assign src_ready           = rdy;
  assign busy                = bsy;
  assign config_done         = done;
  assign config_error        = err;
  assign phase               = state;
endmodule

// ===== dv/fpp_link_asserts.sv
// Concurrent checks on the configuration link pins
`timescale 1ns/10ps
`include "fpp_regs.svh"
module fpp_link_asserts #(
  parameter int cf2ck_cycles = `FPP_CF2CK_CYC
) (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  config_req_n,
  input wire logic                  config_clock,
  input wire logic                  status_in,
  input wire logic                  done_in,
  input wire logic [`FPP_BUS_W-1:0] data
);
  localparam int ST_MIN = 1250;
  localparam int ST_MAX = 12500;
  localparam int ST2CK  = 248;
  int   st_lo, st_wait, req_hi, st_hi, edges;
  int   req_lo, next_req_lo;
  int   next_st_lo, next_st_wait, next_req_hi, next_st_hi, next_edges;
  logic seen_req, clk_q, next_seen_req;

  // Counters run free; a run stays far below their range
  always_comb begin
    next_st_lo    = status_in ? 0 : st_lo + 1;
    next_st_wait  = (status_in || !config_req_n) ? 0 : st_wait + 1;
    next_req_hi   = !config_req_n ? 0 : req_hi + 1;
    next_req_lo   = config_req_n ? 0 : req_lo + 1;
    next_st_hi    = !status_in ? 0 : st_hi + 1;
    next_seen_req = !config_req_n ? 1'b1 : (status_in ? 1'b0 : seen_req);
    next_edges    = !config_req_n ? 0 : edges + int'(config_clock && !clk_q);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {st_lo, st_wait, req_hi, st_hi, edges} <= '0;
      {seen_req, clk_q} <= 2'b00;
      req_lo <= 0;
    end else begin
      {st_lo, st_wait, req_hi, st_hi, edges} <= {next_st_lo, next_st_wait, next_req_hi, next_st_hi, next_edges};
      {seen_req, clk_q} <= {next_seen_req, config_clock};
      req_lo <= next_req_lo;
    end
  end

  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_cd_low; $fell(config_req_n) |-> ##[1:100] !done_in; endproperty
  a_cd_low: assert property (p_cd_low) else $error("done not low in time");
  property p_st_low; $fell(config_req_n) |-> ##[1:100] !status_in; endproperty
  a_st_low: assert property (p_st_low) else $error("status not low in time");
  property p_st_min; $rose(status_in) && seen_req |-> st_lo >= ST_MIN; endproperty
  a_st_min: assert property (p_st_min) else $error("status low too short");
  property p_st_max; st_wait <= ST_MAX; endproperty
  a_st_max: assert property (p_st_max) else $error("status release late");
  property p_por; $fell(rst) |-> (!status_in && !done_in) [*8]; endproperty
  a_por: assert property (p_por) else $error("lines not low after power-up");
  property p_cd_edges; $rose(done_in) |-> edges >= `FPP_IMAGE_BYTES; endproperty
  a_cd_edges: assert property (p_cd_edges) else $error("done before all bytes");
  property p_ck_req; $rose(config_clock) |-> req_hi >= cf2ck_cycles - 2; endproperty
  a_ck_req: assert property (p_ck_req) else $error("clock too soon after request");
  property p_ck_st; $rose(config_clock) |-> status_in && config_req_n && st_hi >= ST2CK; endproperty
  a_ck_st: assert property (p_ck_st) else $error("clock during reset phase");
  property p_hold; config_clock && $past(config_clock) |-> $stable(data); endproperty
  a_hold: assert property (p_hold) else $error("data moved in clock high");
  property p_park; $rose(done_in) |-> ##20 (!config_clock) [*8]; endproperty
  a_park: assert property (p_park) else $error("clock not parked");
  property p_req_len; $rose(config_req_n) |-> req_lo >= `FPP_CFG_CYC; endproperty
  a_req_len: assert property (p_req_len) else $error("request pulse too short");
endmodule

// ===== dv/fpp_config_sequencing_tb.sv
// Testbench joining the host and device ends of the configuration port
`timescale 1ns/10ps
`include "fpp_regs.svh"
module fpp_config_sequencing_tb;
  import fpp_pkg::*;
  localparam int POR   = 200;
  localparam int CF2CK = 300;
  logic            mclk = 1'b0, rst = 1'b1, start = 1'b0, use_user_clock = 1'b0, user_startup_clock = 1'b0;
  logic [7:0]      user_io_out = 8'h00, src_data = 8'h00;
  logic            user_io_oe_n = 1'b1, cfg_ready = 1'b1, src_valid = 1'b0;
  logic            src_ready, busy, config_done, host_err, user_mode, dev_err, cfg_valid;
  logic [7:0]      cfg_data;
  fpp_dev_state_t  dev_phase;
  fpp_host_state_t host_phase;
  int              sent = 0, rcvd = 0, miscompares = 0, checked = 0, n;

  fpp_link_if link ();
  fpp_host #(.cf2ck_cycles(CF2CK)) fpp_host_inst (.mclk(mclk), .rst(rst), .link(link), .start(start),
    .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready), .busy(busy),
    .config_done(config_done), .config_error(host_err), .phase(host_phase));
  fpp_device #(.por_cycles(POR)) fpp_device_inst (.mclk(mclk), .rst(rst), .link(link),
    .use_user_clock(use_user_clock), .user_startup_clock(user_startup_clock), .user_io_out(user_io_out),
    .user_io_oe_n(user_io_oe_n), .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
    .user_mode(user_mode), .config_error(dev_err), .phase(dev_phase));
  fpp_link_asserts #(.cf2ck_cycles(CF2CK)) chk (.mclk(mclk), .rst(rst), .config_req_n(link.config_req_n),
    .config_clock(link.config_clock), .status_in(link.status_in), .done_in(link.done_in), .data(link.data));

  always #4 mclk = ~mclk;
  // User clock unrelated to mclk: 40 ns period, five mclk cycles
  always #20 user_startup_clock = ~user_startup_clock;

  function automatic logic [7:0] pat(input int i);
    return 8'h3c + 8'h1d * i[7:0];
  endfunction

  task automatic check8(input string w, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic sig(input int s);
    case (s)
      1: return user_mode;
      2: return link.done_in;
      3: return dev_err;
      4: return host_err;
      default: return link.status_in;
    endcase
  endfunction

  // Bounded wait; n returns the cycles spent
  task automatic wait_for(input string w, input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v) begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        miscompares++;
        $display("CHECK FAILED %s expected %h seen timeout", w, v);
        results();
      end
    end
  endtask

  always @(posedge mclk) if (src_valid && src_ready === 1'b1) sent <= sent + 1;
  always @(negedge mclk) src_data <= pat(sent);
  always @(posedge mclk) begin
    if (cfg_valid === 1'b1 && cfg_ready) begin
      check8("cfg_data", pat(rcvd), cfg_data);
      rcvd <= rcvd + 1;
    end
  end

  task automatic kick(input logic usr);
    @(negedge mclk);
    use_user_clock = usr;
    sent = 0;
    rcvd = 0;
    start = 1'b1;
    src_valid = 1'b1;
    @(negedge mclk);
    start = 1'b0;
  endtask

  task automatic run_config(input logic usr, input int lo, input int hi);
    kick(usr);
    wait_for("done_low", 2, 1'b0, 100);
    wait_for("status_low", 5, 1'b0, 100);
    wait_for("user_mode_low", 1, 1'b0, 100);
    check8("dev_phase", D_RESET, dev_phase);
    wait_for("done_high", 2, 1'b1, 20000);
    wait_for("user_mode", 1, 1'b1, hi);
    check8("startup_min", 1'b1, n >= lo);
    check8("bytes_rcvd", 8'h20, rcvd[7:0]);
    check8("host_done", 1'b1, config_done);
    check8("host_busy", 1'b0, busy);
    user_io_oe_n = 1'b0;
    user_io_out = pat(usr + 7);
    repeat (3) @(negedge mclk);
    check8("user_io", pat(usr + 7), link.data);
    user_io_oe_n = 1'b1;
    $display("test config user_clock=%0d done", usr);
  endtask

  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    check8("status_por", 1'b0, link.status_in);
    check8("done_por", 1'b0, link.done_in);
    check8("dev_phase", D_POR, dev_phase);
    check8("fifo_empty_por", 1'b0, cfg_valid);
    wait_for("status_high", 5, 1'b1, POR + 20);
    check8("por_length", 1'b1, n >= POR - 4);
    $display("test power-up done");
    run_config(1'b0, 2496, 5000);
    run_config(1'b1, 1550, 1600);
    // Loader stalls so the device buffer overflows mid-image
    cfg_ready = 1'b0;
    kick(1'b0);
    wait_for("dev_error", 3, 1'b1, 20000);
    // Buffer holds sixteen bytes, so the seventeenth edge is the one refused
    check8("fifo_full", 1'b1, cfg_valid);
    check8("fifo_head", pat(0), cfg_data);
    check8("fifo_depth", 8'h11, sent[7:0]);
    wait_for("status_err", 5, 1'b0, 10);
    check8("done_err", 1'b0, link.done_in);
    wait_for("host_error", 4, 1'b1, 100);
    check8("host_phase", H_REQ, host_phase);
    src_valid = 1'b0;
    cfg_ready = 1'b1;
    wait_for("dev_error_clear", 3, 1'b0, 1000);
    // Stalled bytes drain in order once the loader is ready again
    repeat (20) @(negedge mclk);
    check8("fifo_drained", 8'h10, rcvd[7:0]);
    check8("fifo_empty", 1'b0, cfg_valid);
    $display("test overflow done");
    results();
  end
endmodule
